// >>> hdl/jcdio_top.sv
// Function
// - 24 channels as three 8-bit ports
// - per-channel input or output, no direction
// - one channel interrupts, level-edge capture
// - channel select 0-23, default none
// - polarity link picks falling or rising
// - decode four bytes on aligned base
// - base is sum of link weights
// - irq to one of lines 9,3-7
// - no line selected drives nothing
// - shared irq, optional pull-down
// - port read returns inverted pin level
// - write 1 pulls pin low
// - status write clears pending flag unless an edge comes in the same cycle
// - reset clears all output latches
`timescale 1ns/10ps
`include "jcdio_defines.svh"

module jcdio_top (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_b_in,
    // host i/o bus, same clock domain
    input wire jcdio_pkg::jcdio_bus_type bus_in,
    output logic [7:0] rdata_out,
    output logic rdata_valid_out,
    // jumper links, static
    input wire jcdio_pkg::jcdio_cfg_type cfg_in,
    // channel pins, open drain
    input wire logic [23:0] pin_in,
    output logic [23:0] pin_oe_out,
    output logic [23:0] pin_out,
    // host interrupt lines, shared open style
    output logic [5:0] irq_out,
    output logic [5:0] irq_oe_out,
    output logic [5:0] irq_pulldown_out,
    // status
    output logic interrupt_pending_flag_out
);

    // =========================================================
    // pin synchroniser, two stages; first stage read only here
    logic [23:0] pin_meta_reg;
    logic [23:0] pin_sync_reg;
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            pin_meta_reg <= 24'hff_ffff;
            pin_sync_reg <= 24'hff_ffff;
        end else begin
            pin_meta_reg <= pin_in;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // =========================================================
    // address decode
    logic [9:0] base_addr; // sum of installed weights
    logic hit; // bus address falls in window
    logic [1:0] offset; // byte within window
    // links weigh 0x004..0x200; sum equals concatenation
    assign base_addr = {cfg_in.base_links, 2'b00};
    assign hit = (bus_in.addr[9:2] == base_addr[9:2]);
    assign offset = bus_in.addr[1:0];

    // =========================================================
    // three byte ports
    logic [7:0] port_rdata [3];
    logic [2:0] port_wr;
    genvar g;
    generate
        for (g = 0; g < `JCDIO_NUM_PORTS; g++) begin : gen_port
            // channel order: port g holds channels 8g..8g+7
            assign port_wr[g] = hit && bus_in.wr_strobe &&
                (offset == 2'(g));
            jcdio_port u_port (
                .clock_in(clock_in),
                .rst_b_in(rst_b_in),
                .wr_in(port_wr[g]),
                .wdata_in(bus_in.wdata),
                .rdata_out(port_rdata[g]),
                .pin_sync_in(pin_sync_reg[8*g +: 8]),
                .pin_oe_out(pin_oe_out[8*g +: 8]),
                .pin_out(pin_out[8*g +: 8])
            );
        end
    endgenerate

    // =========================================================
    // interrupt source select; out-of-range code means none
    logic chan_valid; // a channel link is fitted
    logic chan_level; // selected channel in active sense
    assign chan_valid = (cfg_in.irq_channel < 5'd24);
    always_comb begin
        chan_level = 1'b0;
        if (chan_valid) begin
            // falling link: active when pin low; rising: when high
            chan_level = cfg_in.rising_select ?
                pin_sync_reg[cfg_in.irq_channel] :
                ~pin_sync_reg[cfg_in.irq_channel];
        end
    end

    // =========================================================
    // level-edge detector
    logic prev_level_reg; // last sampled active sense
    logic edge_seen; // idle-to-active transition
    logic status_wr; // host write to status byte
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            prev_level_reg <= 1'b0;
        end else begin
            prev_level_reg <= chan_level;
        end
    end
    assign edge_seen = chan_level && !prev_level_reg;
    assign status_wr = hit && bus_in.wr_strobe &&
        (offset == `JCDIO_OFF_STATUS);

    // =========================================================
    // pending flag state; set beats clear in the same cycle
    jcdio_pkg::jcdio_irq_state_type state_reg;
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            state_reg <= jcdio_pkg::JCDIO_IDLE;
        end else begin
            unique case (state_reg)
                jcdio_pkg::JCDIO_IDLE: begin
                    // edge caught even for a one-sample pulse
                    if (edge_seen) begin
                        state_reg <= jcdio_pkg::JCDIO_PENDING;
                    end
                end
                jcdio_pkg::JCDIO_PENDING: begin
                    if (status_wr && !edge_seen) begin
                        state_reg <= jcdio_pkg::JCDIO_REARM;
                    end
                end
                jcdio_pkg::JCDIO_REARM: begin
                    // level still active re-raises: level behaviour
                    if (chan_level) begin
                        state_reg <= jcdio_pkg::JCDIO_PENDING;
                    end else begin
                        state_reg <= jcdio_pkg::JCDIO_IDLE;
                    end
                end
                default: begin
                    state_reg <= jcdio_pkg::JCDIO_IDLE;
                end
            endcase
        end
    end
    assign interrupt_pending_flag_out = (state_reg == jcdio_pkg::JCDIO_PENDING);

    // =========================================================
    // host irq drive: shared method drives high only when pending
    always_comb begin
        for (int i = 0; i < `JCDIO_IRQ_LINES; i++) begin
            irq_oe_out[i] = cfg_in.irq_line_sel[i] && interrupt_pending_flag_out;
            irq_out[i] = irq_oe_out[i];
            // pull-down only on the selected line, only if fitted
            irq_pulldown_out[i] = cfg_in.irq_line_sel[i] && cfg_in.pulldown_fit;
        end
        // nothing selected means no enable anywhere
        if (cfg_in.irq_line_sel == 6'h00) begin
            irq_oe_out = 6'h00;
            irq_out = 6'h00;
        end
    end

    // =========================================================
    // read data register; byte wide, no multi-byte fields
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            rdata_out <= 8'h00;
            rdata_valid_out <= 1'b0;
        end else begin
            rdata_valid_out <= hit && bus_in.rd_strobe;
            if (hit && bus_in.rd_strobe) begin
                unique case (offset)
                    `JCDIO_OFF_PORT0: rdata_out <= port_rdata[0];
                    `JCDIO_OFF_PORT1: rdata_out <= port_rdata[1];
                    `JCDIO_OFF_PORT2: rdata_out <= port_rdata[2];
                    `JCDIO_OFF_STATUS: rdata_out <= {7'h00, interrupt_pending_flag_out};
                endcase
            end
        end
    end

    // =========================================================
    // assertions
    a_pend_after_edge: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (state_reg == jcdio_pkg::JCDIO_IDLE && edge_seen) |=> interrupt_pending_flag_out)
        else $error("edge did not set pending");
    a_no_chan_quiet: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        !chan_valid |-> !chan_level)
        else $error("unselected channel active");
    a_status_clear: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (interrupt_pending_flag_out && status_wr && !edge_seen) |=> !interrupt_pending_flag_out)
        else $error("status write did not clear");
    a_irq_follows: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (irq_oe_out != 6'h00) |-> interrupt_pending_flag_out)
        else $error("irq driven without pending");
    a_irq_none: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (cfg_in.irq_line_sel == 6'h00) |-> (irq_oe_out == 6'h00))
        else $error("irq driven with no line");
    a_pulldown_sel: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        !cfg_in.pulldown_fit |-> (irq_pulldown_out == 6'h00))
        else $error("pull-down without option");
    a_write_drives: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        port_wr[0] |=> (pin_oe_out[7:0] == $past(bus_in.wdata)))
        else $error("latch not loaded");
    a_reset_release: assert property (@(posedge clock_in)
        !rst_b_in |=> (pin_oe_out == 24'h00_0000))
        else $error("latch not cleared");
    a_read_valid: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (hit && bus_in.rd_strobe) |=> rdata_valid_out)
        else $error("read not answered");
    c_irq_raised: cover property (@(posedge clock_in) disable iff (!rst_b_in)
        interrupt_pending_flag_out && irq_oe_out != 6'h00);
    c_rearm_level: cover property (@(posedge clock_in) disable iff (!rst_b_in)
        state_reg == jcdio_pkg::JCDIO_REARM ##1 interrupt_pending_flag_out);
    c_port_write: cover property (@(posedge clock_in) disable iff (!rst_b_in)
        port_wr[2]);

endmodule

// >>> hdl/jcdio_defines.svh
`ifndef JCDIO_DEFINES_SVH
`define JCDIO_DEFINES_SVH

// =============================================================
// geometry
`define JCDIO_CHANNELS 24
`define JCDIO_PORT_BITS 8
`define JCDIO_NUM_PORTS 3
`define JCDIO_SEL_BITS 5

// =============================================================
// window offsets (low two address bits)
`define JCDIO_OFF_PORT0 2'h0
`define JCDIO_OFF_PORT1 2'h1
`define JCDIO_OFF_PORT2 2'h2
`define JCDIO_OFF_STATUS 2'h3

// =============================================================
// address decode
`define JCDIO_ADDR_BITS 10
`define JCDIO_BASE_LINKS 8
`define JCDIO_BASE_DEFAULT 8'hc0
`define JCDIO_NO_CHANNEL 5'h1f

// =============================================================
// host irq line selection (one-hot over six lines)
`define JCDIO_IRQ_LINES 6
`define JCDIO_IRQ_9 0
`define JCDIO_IRQ_3 1
`define JCDIO_IRQ_4 2
`define JCDIO_IRQ_5 3
`define JCDIO_IRQ_6 4
`define JCDIO_IRQ_7 5

// =============================================================
// reset values
`define JCDIO_LATCH_RESET 8'h00
`define JCDIO_PEND_BIT 0

`endif

// >>> hdl/jcdio_pkg.sv
package jcdio_pkg;

    // host bus cycle as seen by the block
    typedef struct packed {
        logic [9:0] addr;
        logic       rd_strobe;
        logic       wr_strobe;
        logic [7:0] wdata;
    } jcdio_bus_type;

    // jumper configuration gathered together
    typedef struct packed {
        logic [7:0] base_links;
        logic [4:0] irq_channel;
        logic       rising_select;
        logic [5:0] irq_line_sel;
        logic       pulldown_fit;
    } jcdio_cfg_type;

    // interrupt detector state
    typedef enum logic [1:0] {
        JCDIO_IDLE    = 2'b00,
        JCDIO_PENDING = 2'b01,
        JCDIO_REARM   = 2'b10
    } jcdio_irq_state_type;

endpackage

// >>> hdl/jcdio_port.sv
`timescale 1ns/10ps
`include "jcdio_defines.svh"

// =============================================================
// one byte-wide channel port: output latch, pin drive, readback
module jcdio_port (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_b_in,
    // host side
    input wire logic wr_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] rdata_out,
    // pin side (synchronised pin level in)
    input wire logic [7:0] pin_sync_in,
    output logic [7:0] pin_oe_out,
    output logic [7:0] pin_out
);

    logic [7:0] latch_reg; // 1 means channel is pulled low

    // =========================================================
    // output latch; reset releases every channel
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            latch_reg <= `JCDIO_LATCH_RESET;
        end else if (wr_in) begin
            latch_reg <= wdata_in;
        end
    end

    // open-drain: drive low only, pull-up is external
    assign pin_oe_out = latch_reg;
    assign pin_out = 8'h00;
    // inverted pin level; driven bits read back as the latch
    assign rdata_out = ~pin_sync_in;

endmodule

// >>> bench/jcdio_field_model.sv
`timescale 1ns/10ps

// =============================================================
// field side: pull-up on every channel, open-drain pull-downs
module jcdio_field_model (
    // pull-downs from the block and from field devices
    input wire logic [23:0] pin_oe_in,
    input wire logic [23:0] ext_low_in,
    // resolved pin level
    output logic [23:0] level_out
);
    // wired-and: any pull-down beats the resistor, idle pins sit high
    assign level_out = ~(pin_oe_in | ext_low_in);
endmodule

// >>> bench/tb_jcdio_top.sv
`timescale 1ns/10ps

module tb_jcdio_top;
    // =============================================================
    // stimulus and observed signals
    logic clock_in = 1'b0; // 125 MHz
    logic rst_b_in = 1'b0; // held low for 12 cycles
    jcdio_pkg::jcdio_bus_type bus = '0;
    jcdio_pkg::jcdio_cfg_type cfg = '0;
    logic [23:0] ext_low = '0; // field devices pulling low
    logic [23:0] level, pin_oe, pin_drv;
    logic [7:0] rdata;
    logic rdata_valid, pend;
    logic [5:0] irq, irq_oe, irq_pd;
    logic [31:0] seed = 32'h91f2_0ee7;
    int n_fail = 0;
    int tests_run = 0;
    int latch[3]; // model of the output latches
    logic pend_m = 1'b0; // model of the pending flag
    logic [7:0] last_rd = '0; // read data stands until the next read

    always #4 clock_in = ~clock_in;

    jcdio_top u_jcdio_top (.clock_in(clock_in), .rst_b_in(rst_b_in), .bus_in(bus),
        .rdata_out(rdata), .rdata_valid_out(rdata_valid), .cfg_in(cfg), .pin_in(level),
        .pin_oe_out(pin_oe), .pin_out(pin_drv), .irq_out(irq), .irq_oe_out(irq_oe),
        .irq_pulldown_out(irq_pd), .interrupt_pending_flag_out(pend));
    jcdio_field_model u_jcdio_field_model (.pin_oe_in(pin_oe), .ext_low_in(ext_low),
        .level_out(level));

    // =============================================================
    // helpers
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // expected interrupt outputs: flag, enables, driven level, pull-downs
    function logic [18:0] exp_irq();
        logic [5:0] on;
        on = pend_m ? cfg.irq_line_sel : 6'h00;
        return {pend_m, on, on, cfg.pulldown_fit ? cfg.irq_line_sel : 6'h00};
    endfunction

    task automatic fail_line(input logic [23:0] got, input logic [23:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_read(input logic [8:0] got, input logic [8:0] exp);
        fail_line({15'h0000, got}, {15'h0000, exp});
    endtask

    task automatic chk_pins(input logic [23:0] got, input logic [23:0] exp);
        fail_line(got, exp);
    endtask

    task automatic chk_irq(input logic [18:0] got);
        fail_line({5'h00, got}, {5'h00, exp_irq()});
    endtask

    // one host cycle; strobe held for exactly the sampling edge
    task automatic acc(input logic [9:0] a, input logic w, input logic [7:0] d,
        output logic [8:0] q);
        @(posedge clock_in);
        #1;
        bus = '{addr: a, rd_strobe: ~w, wr_strobe: w, wdata: d};
        @(posedge clock_in);
        #1;
        bus.rd_strobe = 1'b0;
        bus.wr_strobe = 1'b0;
        q = {rdata_valid, rdata};
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask

    task complete_run();
        if (n_fail == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // =============================================================
    // watchdog: whole run needs well under 2000 cycles
    initial begin
        #60000;
        n_fail++;
        complete_run();
    end

    // =============================================================
    // main sequence
    initial begin
        logic [8:0] q;
        logic [7:0] b, e;
        int p, ch;
        cfg = '{base_links: 8'hc0, irq_channel: 5'h1f, rising_select: 1'b0,
            irq_line_sel: 6'h00, pulldown_fit: 1'b0};
        repeat (12) @(posedge clock_in);
        #1 rst_b_in = 1'b1;
        wait_cyc(3);
        chk_pins(pin_oe, 24'h00_0000);
        chk_pins(pin_drv, 24'h00_0000);
        chk_irq({pend, irq_oe, irq & irq_oe, irq_pd});
        // random bases, latches and field levels; no channel selected
        for (int i = 0; i < 12; i++) begin
            b = (i == 0) ? 8'hc0 : rnd();
            cfg.base_links = b;
            p = rnd() % 3;
            e = rnd();
            ext_low = rnd();
            acc({b, p[1:0]}, 1'b1, e, q);
            latch[p] = e;
            acc({b ^ (8'h01 << (i % 8)), p[1:0]}, 1'b1, rnd(), q);
            wait_cyc(4);
            chk_pins(pin_oe, {latch[2][7:0], latch[1][7:0], latch[0][7:0]});
            for (int k = 0; k < 3; k++) begin
                acc({b, k[1:0]}, 1'b0, 8'h00, q);
                last_rd = latch[k][7:0] | ext_low[8*k +: 8];
                chk_read(q, {1'b1, last_rd});
            end
            acc({~b, 2'h1}, 1'b0, 8'h00, q);
            chk_read(q, {1'b0, last_rd});
            chk_irq({pend, irq_oe, irq & irq_oe, irq_pd});
        end
        // interrupt: every line, both polarities, pull-down on and off
        cfg.base_links = 8'hc0;
        for (int k = 0; k < 3; k++) acc({8'hc0, k[1:0]}, 1'b1, 8'h00, q);
        for (int i = 0; i < 13; i++) begin
            ch = rnd() % 24;
            ext_low = i[0] ? (24'h00_0001 << ch) : 24'h00_0000;
            cfg.irq_channel = ch[4:0];
            cfg.rising_select = i[0];
            cfg.irq_line_sel = (i == 12) ? 6'h00 : 6'h01 << (i % 6);
            cfg.pulldown_fit = i[1];
            wait_cyc(6);
            acc({8'hc0, 2'h3}, 1'b1, rnd(), q);
            pend_m = 1'b0;
            wait_cyc(6);
            chk_irq({pend, irq_oe, irq & irq_oe, irq_pd});
            ext_low = ext_low ^ (24'h00_0001 << ((ch + 1) % 24));
            wait_cyc(2);
            ext_low = ext_low ^ (24'h00_0001 << ((ch + 1) % 24));
            wait_cyc(6);
            chk_irq({pend, irq_oe, irq & irq_oe, irq_pd});
            ext_low = ext_low ^ (24'h00_0001 << ch);
            wait_cyc(1);
            ext_low = ext_low ^ (24'h00_0001 << ch);
            wait_cyc(6);
            pend_m = 1'b1;
            chk_irq({pend, irq_oe, irq & irq_oe, irq_pd});
            acc({8'hc0, 2'h3}, 1'b0, 8'h00, q);
            chk_read(q, 9'h101);
            acc({8'hc0, 2'h3}, 1'b1, rnd(), q);
            pend_m = 1'b0;
            wait_cyc(4);
            chk_irq({pend, irq_oe, irq & irq_oe, irq_pd});
        end
        complete_run();
    end
endmodule
